// ---- shared/pst_pkg.sv ----
// package: constants and carrier types of the program supervisor timer
package pst_pkg;

    // ------------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_SVC  = 8'h00; // service_key_register
    localparam logic [7:0] ADDR_CTRL = 8'h04; // power mode and oscillator
    localparam logic [7:0] ADDR_STAT = 8'h08; // sticky event status
    localparam logic [7:0] ADDR_CLR  = 8'h0c; // write one to clear status
    localparam logic [7:0] ADDR_IEN  = 8'h10; // interrupt enable
    localparam logic [7:0] ADDR_TMR  = 8'h14; // idle_interval_timer value

    // ------------------------------------------------------------------
    // service byte layout
    // ------------------------------------------------------------------
    localparam int         SVC_SEL_HI = 7;
    localparam int         SVC_SEL_LO = 6;
    localparam int         SVC_KEY_HI = 5;
    localparam int         SVC_KEY_LO = 1;
    localparam int         SVC_CM_BIT = 0;
    localparam logic [4:0] SVC_KEY    = 5'h0c;
    localparam logic [1:0] SEL_RESET  = 2'h3;
    localparam logic       CM_RESET   = 1'h1;

    // ------------------------------------------------------------------
    // control bits
    // ------------------------------------------------------------------
    localparam int         CTRL_HALT   = 0;
    localparam int         CTRL_IDLE   = 1;
    localparam int         CTRL_RC_OSC = 2;
    localparam int         CTRL_DELAY  = 3; // clock_start_delay_bit
    localparam int         CTRL_W      = 4;
    localparam logic [3:0] CTRL_RESET  = 4'h0;

    // ------------------------------------------------------------------
    // status bits and timing
    // ------------------------------------------------------------------
    localparam int          ST_SUP_ERR = 0;
    localparam int          ST_CM_ERR  = 1;
    localparam int          ST_TICK    = 2; // idle_tick_pending
    localparam int          ST_W       = 3;
    localparam int          LOWER_CYC  = 256;
    localparam int          HOLD_CYC   = 16;
    localparam int          TMR_W      = 16;
    localparam int          TICK_BIT   = 12;
    localparam int          WIN_W      = 17;

    typedef enum logic [1:0] {
        F_IDLE,
        F_DRIVE,
        F_HOLD,
        F_RELEASE
    } pst_fault_type;

    typedef struct packed {
        logic       valid;
        logic       write;
        logic [7:0] addr;
    } pst_bus_req_type;

endpackage : pst_pkg

// ---- rtl/pst_window_timer.sv ----
// service window counter with lower and upper limit flags
`timescale 1ns/1ns
`default_nettype none
module pst_window_timer
    import pst_pkg::*;
#(
    parameter int unsigned WIN_UNIT = 8192
)(
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // control
    input  wire logic       restart,
    input  wire logic       hold,
    input  wire logic [1:0] sel,
    // flags
    output logic            early,
    output logic            expired
);
    logic [WIN_W-1:0] cnt_q;
    logic [WIN_W-1:0] cnt_d;
    logic [WIN_W-1:0] limit;

    // 8k, 16k, 32k, 64k: unit doubled per select step
    assign limit   = WIN_W'(WIN_UNIT) << sel;
    assign early   = cnt_q < WIN_W'(LOWER_CYC);
    assign expired = cnt_q >= limit - WIN_W'(1);

    always_comb
    begin
        cnt_d = cnt_q;
        if (restart)
        begin
            cnt_d = '0;
        end
        else if (!hold && !expired)
        begin
            cnt_d = cnt_q + WIN_W'(1);
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            cnt_q <= '0;
        end
        else
        begin
            cnt_q <= cnt_d;
        end
    end
endmodule : pst_window_timer
`default_nettype wire

// ---- rtl/pst_top.sv ----
// program supervisor timer with clock monitor and AHB-Lite registers
//
// Implementation choices: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/1ns
`default_nettype none
// Summary of operation
// - detectors stay inhibited while reset is asserted.
// - after reset both checks enabled, largest service window selected.
// - window select and monitor enable change only at first service.
// - first service must carry the key, else supervisor error.
// - later services must match select, key and monitor bit.
// - reads of the service register show zeros in the key field.
// - timeout detection is suspended in halt and idle.
// - clock monitor stays active; halt with monitor enabled is an error.
// - RC oscillator without start delay resumes the window after halt.
// - crystal, or RC with start delay, reloads the window after halt.
// - external reset leaves the idle timer count alone.
// - idle tick flag sets on every bit twelve toggle; software clears.
// - leaving idle performs an automatic service.
// - first service is accepted anywhere in the initial window.
// - service byte: select 7:6, key 5:1, monitor enable bit 0.
// - select codes give 8k, 16k, 32k, 64k cycle upper limits.
// - fault output held low 16 more cycles after pin reads low.
// - service during fault ignored; window restarts when pin rises.
module pst_top
    import pst_pkg::*;
#(
    parameter int unsigned WIN_UNIT = 8192
)(
    // clock and resets
    input  wire logic        CLK,
    input  wire logic        RST,
    input  wire logic        POR,
    // AHB-Lite slave
    input  wire logic        HSEL,
    input  wire logic [31:0] HADDR,
    input  wire logic [1:0]  HTRANS,
    input  wire logic        HWRITE,
    input  wire logic [2:0]  HSIZE,
    input  wire logic [31:0] HWDATA,
    input  wire logic        HREADY,
    output logic [31:0]      HRDATA,
    output logic             HREADYOUT,
    output logic             HRESP,
    // fault pin, open drain
    input  wire logic        FAULT_I,
    output logic             FAULT_O,
    output logic             FAULT_OE_N,
    // slow clock detector input
    input  wire logic        SLOW_CLK_I,
    // interrupt
    output logic             IRQ
);
    import pst_pkg::*;

    // ------------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------------
    pst_bus_req_type     req_q, req_d;
    logic [31:0]         rdata_d;
    logic [1:0]          sel_q, sel_d;
    logic                cm_en_q, cm_en_d;
    logic                first_q, first_d;
    logic [CTRL_W-1:0]   ctrl_q, ctrl_d;
    logic [ST_W-1:0]     stat_q, stat_d, ien_q, ien_d, ev;
    pst_fault_type       state_q, state_d;
    logic [4:0]          hold_q, hold_d;
    logic                oe_n_d, irq_d;
    logic [2:0]          fpin_q, spin_q;
    logic                fpin_f_q, spin_f_q, fpin_f_d, spin_f_d;
    logic [TMR_W-1:0]    tmr_q;
    logic                svc_wr, wr_ctrl, key_ok, all_ok, fault_on;
    logic                suspend, halt_exit, idle_exit, cm_err;
    logic                sup_err, restart, early, expired, tick;
    logic [7:0]          wb;

    assign wb       = HWDATA[7:0];
    assign svc_wr   = req_q.valid && req_q.write && req_q.addr == ADDR_SVC;
    assign wr_ctrl  = req_q.valid && req_q.write && req_q.addr == ADDR_CTRL;
    assign fault_on = state_q != F_IDLE;
    assign key_ok   = wb[SVC_KEY_HI:SVC_KEY_LO] == SVC_KEY;
    assign all_ok   = key_ok && wb[SVC_SEL_HI:SVC_SEL_LO] == sel_q
                      && wb[SVC_CM_BIT] == cm_en_q;
    assign suspend  = ctrl_q[CTRL_HALT] || ctrl_q[CTRL_IDLE];
    assign cm_err   = cm_en_q && (ctrl_q[CTRL_HALT] || spin_f_q);

    // ------------------------------------------------------------------
    // bus slave: zero wait, always OKAY
    // ------------------------------------------------------------------
    always_comb
    begin
        req_d.valid = HSEL && HTRANS[1] && HREADY;
        req_d.write = HWRITE;
        req_d.addr  = HADDR[7:0];
        rdata_d     = 32'h0;
        if (!req_d.valid || HWRITE)
        begin
            rdata_d = 32'h0;
        end
        else if (HADDR[7:0] == ADDR_SVC)
        begin
            rdata_d[7:0] = {sel_q, 5'h00, cm_en_q};
        end
        else if (HADDR[7:0] == ADDR_CTRL)
        begin
            rdata_d[CTRL_W-1:0] = ctrl_q;
        end
        else if (HADDR[7:0] == ADDR_STAT)
        begin
            rdata_d[ST_W-1:0] = stat_q;
        end
        else if (HADDR[7:0] == ADDR_IEN)
        begin
            rdata_d[ST_W-1:0] = ien_q;
        end
        else if (HADDR[7:0] == ADDR_TMR)
        begin
            rdata_d[TMR_W-1:0] = tmr_q;
        end
    end

    // ------------------------------------------------------------------
    // service handling and settings
    // ------------------------------------------------------------------
    always_comb
    begin
        sel_d   = sel_q;
        cm_en_d = cm_en_q;
        first_d = first_q;
        ctrl_d  = ctrl_q;
        sup_err = 1'b0;
        restart = 1'b0;
        if (wr_ctrl)
        begin
            ctrl_d = wb[CTRL_W-1:0];
        end
        if (svc_wr && !fault_on)
        begin
            if (first_q)
            begin
                // no lower limit check on the first service
                if (key_ok)
                begin
                    sel_d   = wb[SVC_SEL_HI:SVC_SEL_LO];
                    cm_en_d = wb[SVC_CM_BIT];
                    first_d = 1'b0;
                    restart = 1'b1;
                end
                else
                begin
                    sup_err = 1'b1;
                end
            end
            else if (!all_ok || early)
            begin
                sup_err = 1'b1;
            end
            else
            begin
                restart = 1'b1;
            end
        end
        // timeout only counts outside low power
        if (expired && !suspend && !fault_on)
        begin
            sup_err = 1'b1;
        end
        // an RC clock without start delay keeps the count
        if (halt_exit && !(ctrl_q[CTRL_RC_OSC] && !ctrl_q[CTRL_DELAY]))
        begin
            restart = 1'b1;
        end
        if (idle_exit)
        begin
            restart = 1'b1;
        end
        if (state_q == F_RELEASE && fpin_f_q)
        begin
            restart = 1'b1;
        end
    end

    assign halt_exit = wr_ctrl && ctrl_q[CTRL_HALT] && !wb[CTRL_HALT];
    assign idle_exit = wr_ctrl && ctrl_q[CTRL_IDLE] && !wb[CTRL_IDLE];

    // window counter
    pst_window_timer #(
        .WIN_UNIT (WIN_UNIT)
    ) u_win (
        .clk     (CLK),
        .rst     (RST),
        .restart (restart),
        .hold    (suspend || fault_on),
        .sel     (sel_q),
        .early   (early),
        .expired (expired)
    );

    // ------------------------------------------------------------------
    // fault pin sequencing
    // ------------------------------------------------------------------
    always_comb
    begin
        state_d = state_q;
        hold_d  = hold_q;
        oe_n_d  = 1'b1;
        case (state_q)
            F_IDLE:
            begin
                if (sup_err || cm_err)
                begin
                    state_d = F_DRIVE;
                    oe_n_d  = 1'b0;
                end
            end
            F_DRIVE:
            begin
                oe_n_d = 1'b0;
                hold_d = 5'h00;
                if (!fpin_f_q)
                begin
                    state_d = F_HOLD;
                end
            end
            F_HOLD:
            begin
                oe_n_d = 1'b0;
                // a lasting clock error keeps the pin low
                if (cm_err)
                begin
                    hold_d = 5'h00;
                end
                else if (hold_q == 5'(HOLD_CYC - 1))
                begin
                    state_d = F_RELEASE;
                    oe_n_d  = 1'b1;
                end
                else
                begin
                    hold_d = hold_q + 5'h01;
                end
            end
            F_RELEASE:
            begin
                if (fpin_f_q)
                begin
                    state_d = F_IDLE;
                end
            end
            default:
            begin
                state_d = F_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // pin filters: second and third stages must agree
    // ------------------------------------------------------------------
    always_comb
    begin
        fpin_f_d = (fpin_q[1] == fpin_q[2]) ? fpin_q[2] : fpin_f_q;
        spin_f_d = (spin_q[1] == spin_q[2]) ? spin_q[2] : spin_f_q;
    end

    // ------------------------------------------------------------------
    // status and interrupt
    // ------------------------------------------------------------------
    assign tick = &tmr_q[TICK_BIT-1:0];
    always_comb
    begin
        ev              = '0;
        ev[ST_SUP_ERR]  = sup_err;
        ev[ST_CM_ERR]   = cm_err;
        ev[ST_TICK]     = tick;
        stat_d          = stat_q;
        ien_d           = ien_q;
        if (req_q.valid && req_q.write && req_q.addr == ADDR_CLR)
        begin
            stat_d = stat_d & ~wb[ST_W-1:0];
        end
        if (req_q.valid && req_q.write && req_q.addr == ADDR_IEN)
        begin
            ien_d = wb[ST_W-1:0];
        end
        // a new event beats a clear in the same cycle
        stat_d = stat_d | ev;
        irq_d  = |(stat_d & ien_d);
    end

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            req_q      <= '0;
            HRDATA     <= 32'h0;
            HREADYOUT  <= 1'b1;
            HRESP      <= 1'b0;
            sel_q      <= SEL_RESET;
            cm_en_q    <= CM_RESET;
            first_q    <= 1'b1;
            ctrl_q     <= CTRL_RESET;
            stat_q     <= '0;
            ien_q      <= '0;
            state_q    <= F_IDLE;
            hold_q     <= 5'h00;
            FAULT_O    <= 1'b0;
            FAULT_OE_N <= 1'b1;
            fpin_q     <= 3'h7;
            spin_q     <= 3'h0;
            fpin_f_q   <= 1'b1;
            spin_f_q   <= 1'b0;
            IRQ        <= 1'b0;
        end
        else
        begin
            req_q      <= req_d;
            HRDATA     <= rdata_d;
            HREADYOUT  <= 1'b1;
            HRESP      <= 1'b0;
            sel_q      <= sel_d;
            cm_en_q    <= cm_en_d;
            first_q    <= first_d;
            ctrl_q     <= ctrl_d;
            stat_q     <= stat_d;
            ien_q      <= ien_d;
            state_q    <= state_d;
            hold_q     <= hold_d;
            FAULT_O    <= 1'b0;
            FAULT_OE_N <= oe_n_d;
            fpin_q     <= {fpin_q[1:0], FAULT_I};
            spin_q     <= {spin_q[1:0], SLOW_CLK_I};
            fpin_f_q   <= fpin_f_d;
            spin_f_q   <= spin_f_d;
            IRQ        <= irq_d;
        end
    end

    // idle timer only clears at power on, never on RST
    always_ff @(posedge CLK or posedge POR)
    begin
        if (POR)
        begin
            tmr_q <= '0;
        end
        else
        begin
            tmr_q <= tmr_q + TMR_W'(1);
        end
    end

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);

    key_read_a: assert property (
        req_d.valid && !HWRITE && HADDR[7:0] == ADDR_SVC
        |=> HRDATA[5:1] == 5'h00)
        else $error("service read shows key bits");
    reset_win_a: assert property (
        first_q |-> sel_q == SEL_RESET && cm_en_q == CM_RESET)
        else $error("settings left reset values before first service");
    lock_sel_a: assert property (
        !$past(first_q) |-> $stable(sel_q) && $stable(cm_en_q))
        else $error("settings changed after first service");
    bad_key_a: assert property (
        svc_wr && first_q && !key_ok && !fault_on |=> state_q == F_DRIVE)
        else $error("bad first key not flagged");
    mismatch_a: assert property (
        svc_wr && !first_q && !all_ok && !fault_on |=> state_q == F_DRIVE)
        else $error("mismatched service not flagged");
    early_svc_a: assert property (
        svc_wr && !first_q && early && !fault_on |=> state_q == F_DRIVE)
        else $error("early service not flagged");
    first_any_a: assert property (
        svc_wr && first_q && key_ok && !fault_on && !cm_err
        && !(expired && !suspend) |=> state_q == F_IDLE && !first_q)
        else $error("valid first service refused");
    suspend_a: assert property (
        !fault_on && suspend && !cm_err && !svc_wr |=> !fault_on)
        else $error("timeout raised in low power mode");
    halt_cm_a: assert property (
        !fault_on && cm_en_q && ctrl_q[CTRL_HALT] |=> !FAULT_OE_N)
        else $error("halt with monitor on not reported");
    tick_set_a: assert property (
        tick |=> stat_q[ST_TICK])
        else $error("idle tick flag not set");
    hold_len_a: assert property (
        $rose(FAULT_OE_N) |-> $past(hold_q) == 5'(HOLD_CYC - 1)
        && $past(state_q) == F_HOLD)
        else $error("fault released before hold time");
    ignore_a: assert property (
        svc_wr && fault_on |=> $stable(first_q) && $stable(sel_q))
        else $error("service accepted while fault active");
endmodule : pst_top
`default_nettype wire

// ---- dv/pst_fault_line.sv ----
// open-drain fault line with its weak pull-up, as the reset logic sees it
`timescale 1ns/1ns
`default_nettype none
module pst_fault_line (
    // device side
    input  wire logic drive_oe_n,
    input  wire logic drive_val,
    // wire level
    output logic      pin
);
    // released line rises through the pull-up, it never keeps a stale low
    assign pin = (!drive_oe_n && !drive_val) ? 1'b0 : 1'b1;
endmodule : pst_fault_line
`default_nettype wire

// ---- dv/pst_top_tb_top.sv ----
// self-checking bench of the program supervisor timer
`timescale 1ns/1ns
`default_nettype none
module pst_top_tb_top;
    import pst_pkg::*;
    localparam int unsigned UNIT = 512;
    logic        clk, rst, por, hsel, hwrite, slow, pin;
    logic        hready, hresp, fo, foe_n, irq, fault_seen;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0]  htrans, sel;
    logic [2:0]  hsize;
    logic [3:0]  mode;
    logic [15:0] t1, dt;
    int          miscompares, n_checks, cyc, win;

    pst_top #(.WIN_UNIT(UNIT)) i_dut (.CLK(clk), .RST(rst), .POR(por),
        .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
        .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hready), .HRDATA(hrdata),
        .HREADYOUT(hready), .HRESP(hresp), .FAULT_I(pin), .FAULT_O(fo),
        .FAULT_OE_N(foe_n), .SLOW_CLK_I(slow), .IRQ(irq));
    pst_fault_line i_line (.drive_oe_n(foe_n), .drive_val(fo), .pin(pin));

    // ------------
    // clock, hang guard, fault watch
    // ------------
    always #5 clk = ~clk;
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (foe_n === 1'b0)
            fault_seen <= 1'b1;
        if (cyc == 30000)
        begin
            miscompares++;
            print_verdict;
        end
    end

    // ------------
    // checks and bus cycles
    // ------------
    task automatic chk32(input string nm, input logic [31:0] e,
                         input logic [31:0] g);
        n_checks++;
        if (g !== e)
        begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask : chk32

    task automatic chk1(input string nm, input logic e, input logic g);
        n_checks++;
        if (g !== e)
        begin
            miscompares++;
            $display("wrong value %s expected %b seen %b", nm, e, g);
        end
    endtask : chk1

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : wait_cyc

    // called right after a rising edge; returns at the data-phase edge
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] wd, output logic [31:0] rdo);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr  <= {24'h0, a};
        hsize  <= 3'h2;
        @(posedge clk);
        while (hready !== 1'b1) @(posedge clk);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge clk);
        while (hready !== 1'b1) @(posedge clk);
        rdo = hrdata;
    endtask : bus

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d, rd);
    endtask : wr

    task automatic rdchk(input string nm, input logic [7:0] a,
                         input logic [31:0] m, input logic [31:0] e);
        bus(1'b0, a, 32'h0, rd);
        chk32(nm, e, rd & m);
    endtask : rdchk

    function automatic logic [31:0] svc(input logic [1:0] s,
                                        input logic [4:0] k, input logic c);
        return {24'h0, s, k, c};
    endfunction : svc

    // onset within lo..hi cycles, then optionally the low time
    task automatic expect_fault(input int lo, input int hi, input bit meas);
        int k;
        k = 0;
        while (foe_n !== 1'b0 && k <= hi)
        begin
            @(posedge clk);
            k++;
        end
        slow <= 1'b0;
        chk1("fault onset", 1'b1, k >= lo && k <= hi);
        chk1("fault level", 1'b0, fo);
        if (meas)
        begin
            k = 0;
            while (foe_n === 1'b0 && k < 60)
            begin
                @(posedge clk);
                k++;
            end
            chk1("fault hold", 1'b1, k >= 16 && k <= 32);
            wait_cyc(12);
        end
    endtask : expect_fault

    task automatic no_fault(input string nm);
        wait_cyc(4);
        chk1(nm, 1'b0, fault_seen);
    endtask : no_fault

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : print_verdict

    // ------------
    // main sequence
    // ------------
    initial
    begin
        clk = 0; rst = 1; por = 1; hsel = 0; htrans = 0; hwrite = 0;
        haddr = 0; hwdata = 0; hsize = 3'h2; slow = 0; fault_seen = 0;
        miscompares = 0; n_checks = 0; cyc = 0;
        void'($urandom(71));
        sel = 2'($urandom_range(1, 0));
        win = UNIT << sel;
        wait_cyc(20);
        chk1("oe in reset", 1'b1, foe_n);
        rst <= 1'b0;
        por <= 1'b0;
        @(posedge clk);
        chk1("hresp", 1'b0, hresp);
        rdchk("service", ADDR_SVC, 32'hff, 32'hc1);
        rdchk("unmapped", 8'h1c, 32'hffffffff, 32'h0);
        wr(ADDR_IEN, 32'h7);
        wr(ADDR_SVC, svc(sel, SVC_KEY, 1'b0));
        rdchk("service", ADDR_SVC, 32'hff, {24'h0, sel, 6'h0});
        repeat (3)
        begin
            wait_cyc($urandom_range(win - 60, 260));
            wr(ADDR_SVC, svc(sel, SVC_KEY, 1'b0));
        end
        no_fault("good services");
        // changed select, wrong key, changed monitor bit, too early
        for (int i = 0; i < 4; i++)
        begin
            wait_cyc(i == 3 ? 100 : 300);
            wr(ADDR_SVC, i == 0 ? svc({sel[1], ~sel[0]}, SVC_KEY, 1'b0) :
                i == 1 ? svc(sel, SVC_KEY ^ 5'h01, 1'b0) :
                svc(sel, SVC_KEY, i == 2));
            expect_fault(1, 3, 1);
            rdchk("status", ADDR_STAT, 32'h3, 32'h1);
            chk1("irq", 1'b1, irq);
            wr(ADDR_CLR, 32'h1);
        end
        rdchk("status", ADDR_STAT, 32'h3, 32'h0);
        expect_fault(win - 30, win + 4, 1);
        wr(ADDR_CLR, 32'h1);
        wait_cyc(win - 150);
        fault_seen = 0;
        wr(ADDR_CTRL, 32'h2);
        wait_cyc(4200);
        rdchk("tick", ADDR_STAT, 32'h4, 32'h4);
        chk1("tick irq", 1'b1, irq);
        wr(ADDR_CLR, 32'h4);
        rdchk("tick", ADDR_STAT, 32'h4, 32'h0);
        wr(ADDR_CTRL, 32'h0);
        wait_cyc(300);
        wr(ADDR_SVC, svc(sel, SVC_KEY, 1'b0));
        no_fault("idle");
        // crystal, rc without start delay, rc with start delay
        for (int i = 0; i < 3; i++)
        begin
            mode = i == 0 ? 4'h0 : i == 1 ? 4'h4 : 4'hc;
            wait_cyc(win - 150);
            fault_seen = 0;
            wr(ADDR_CTRL, {28'h0, mode | 4'h1});
            wait_cyc(50);
            wr(ADDR_CTRL, {28'h0, mode});
            if (i == 1)
                expect_fault(120, 160, 1);
            else
            begin
                wait_cyc(300);
                wr(ADDR_SVC, svc(sel, SVC_KEY, 1'b0));
                no_fault("halt reload");
            end
        end
        bus(1'b0, ADDR_TMR, 32'h0, rd);
        t1 = rd[15:0];
        rst <= 1'b1;
        slow <= 1'b1;
        wait_cyc(20);
        chk1("oe in reset", 1'b1, foe_n);
        rst <= 1'b0;
        @(posedge clk);
        expect_fault(1, 12, 1);
        bus(1'b0, ADDR_TMR, 32'h0, rd);
        dt = rd[15:0] - t1;
        chk1("timer kept", 1'b1, dt >= 16'h14 && dt <= 16'h60);
        rdchk("service", ADDR_SVC, 32'hff, 32'hc1);
        rdchk("status", ADDR_STAT, 32'h3, 32'h2);
        chk1("masked irq", 1'b0, irq);
        wr(ADDR_SVC, svc(2'h0, SVC_KEY ^ 5'h10, 1'b1));
        expect_fault(1, 3, 1);
        fault_seen = 0;
        wr(ADDR_SVC, svc(2'h0, SVC_KEY, 1'b1));
        no_fault("first key");
        wr(ADDR_CTRL, 32'h1);
        expect_fault(1, 8, 0);
        wr(ADDR_CLR, 32'h3);
        // a bad service while the halt error holds the pin must be ignored
        wr(ADDR_SVC, svc(2'h3, SVC_KEY ^ 5'h01, 1'b0));
        wait_cyc(2);
        rdchk("status", ADDR_STAT, 32'h3, 32'h2);
        rdchk("service", ADDR_SVC, 32'hff, 32'h01);
        print_verdict;
    end
endmodule : pst_top_tb_top
`default_nettype wire
